// File: src/hdc_health_cmd.sv
/*
  Drive-side health data commands: task-file registers, read of the
  attribute-value and threshold blocks, autosave control, over Wishbone.
  Assumes a classic Wishbone master and drive firmware for status fields.
*/
`timescale 1ns/1ps
module hdc_health_cmd
  import hdc_pkg::*;
#(
  parameter logic UNIT_ID = 1'h0
)
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_change_i,
  input wire logic normal_save_i,
  input wire logic nv_autosave_i,
  output logic nv_autosave_o,
  output logic nv_wr_o,
  output logic save_req_o,
  output logic intrq_o,
  output logic bsy_o,
  output logic drq_o
);

  hdc_state_t s_r;
  hdc_state_t s_nxt;
  hdc_blk_if blk ();

  logic acc;
  logic srst;
  logic [31:0] wd;
  logic [31:0] rd;
  logic [31:0] cur;
  logic [7:0] st8;
  logic [15:0] adv;
  logic [15:0] word_out;
  logic [3:0] rem;

  function automatic logic [31:0] hdc_merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        m[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return m;
  endfunction : hdc_merge

  // next word index plus entry counters; entries start at word 1
  function automatic logic [15:0] hdc_adv(input logic [7:0] w,
    input logic [4:0] ent, input logic [2:0] ewd);
    logic [4:0] e;
    logic [2:0] k;
    e = ent;
    k = ewd;
    if (w != 8'h00)
    begin
      if (ewd == HDC_EWD_LAST)
      begin
        k = 3'h0;
        e = ent + 5'h01;
      end
      else
      begin
        k = ewd + 3'h1;
      end
    end
    return {w + 8'h01, e, k};
  endfunction : hdc_adv

  assign blk.thr_sel = s_r.thr_sel;
  assign blk.w = s_r.w;
  assign blk.ewd = s_r.ewd;
  assign blk.entry = (s_r.ent < HDC_ENT_CNT) ? s_r.tbl[s_r.ent] : 16'h0000;
  assign blk.ostat = s_r.ostat;
  assign blk.stest = s_r.stest;
  assign blk.otime = s_r.otime;
  assign blk.poll = s_r.poll;
  assign blk.abort_cap = s_r.abort_cap;

  hdc_block_rom u_rom (
    .b(blk)
  );

  // last word carries the checksum in its high byte
  assign word_out = (s_r.w == HDC_W_LAST) ?
    {~s_r.sum + 8'h01, blk.pair[7:0]} : blk.pair;

  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign nv_autosave_o = s_r.autosave;
  assign nv_wr_o = s_r.nv_wr;
  assign save_req_o = s_r.save_req;
  assign intrq_o = s_r.intrq & ~s_r.nien;
  assign bsy_o = s_r.bsy;
  assign drq_o = s_r.drq;

  always_comb
  begin
    s_nxt = s_r;
    acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
    srst = 1'h0;
    rd = 32'h00000000;
    cur = 32'h00000000;
    rem = 4'h0;
    st8 = 8'h00;
    st8[HDC_SB_BSY] = s_r.bsy;
    st8[HDC_SB_DRQ] = s_r.drq;
    st8[HDC_SB_INTRQ] = s_r.intrq;
    st8[HDC_SB_ERR] = s_r.err;
    adv = hdc_adv(s_r.w, s_r.ent, s_r.ewd);
    s_nxt.ack = acc;
    s_nxt.nv_wr = 1'h0;

    // readback of the addressed register, also the base for byte merges
    case (wb_adr_i)
      HDC_A_FEAT: cur = {24'h000000, s_r.feat};
      HDC_A_CNT: cur = {24'h000000, s_r.cnt};
      HDC_A_SUB: cur = {24'h000000, s_r.sub};
      HDC_A_TRK: cur = {16'h0000, s_r.trk};
      HDC_A_HEAD: cur = {28'h0000000, s_r.head};
      HDC_A_UNIT: cur = {31'h00000000, s_r.unit};
      HDC_A_CMD: cur = {24'h000000, st8};
      HDC_A_DEVST: cur = {16'h0000, s_r.stest, s_r.ostat};
      HDC_A_TIMES: cur = {s_r.poll, s_r.otime};
      HDC_A_CAP: cur = {30'h00000000, s_r.autosave, s_r.abort_cap};
      HDC_A_TBL:
      begin
        // index past the last entry has no storage behind it
        if (s_r.tptr < HDC_ENT_CNT)
        begin
          cur = {8'h00, s_r.tbl[s_r.tptr], 3'h0, s_r.tptr};
        end
        else
        begin
          cur = {24'h000000, 3'h0, s_r.tptr};
        end
      end
      HDC_A_ERR: cur = {29'h00000000, s_r.err, 2'h0};
      HDC_A_DEVCTL: cur = {24'h000000, st8};
      default: cur = 32'h00000000;
    endcase
    wd = hdc_merge(cur, wb_dat_i, wb_sel_i);

    // autosave state comes back from non-volatile storage after reset
    if (!s_r.nv_ld)
    begin
      s_nxt.nv_ld = 1'h1;
      s_nxt.autosave = nv_autosave_i;
    end

    // save on mode change only when enabled; normal saves always pass
    s_nxt.save_req = normal_save_i
      | (mode_change_i & s_r.autosave);

    if (acc && wb_we_i)
    begin
      case (wb_adr_i)
        HDC_A_FEAT: if (!s_r.bsy) s_nxt.feat = wd[7:0];
        HDC_A_CNT: if (!s_r.bsy) s_nxt.cnt = wd[7:0];
        HDC_A_SUB: if (!s_r.bsy) s_nxt.sub = wd[7:0];
        HDC_A_TRK: if (!s_r.bsy) s_nxt.trk = wd[15:0];
        HDC_A_HEAD: if (!s_r.bsy) s_nxt.head = wd[3:0];
        HDC_A_UNIT: if (!s_r.bsy) s_nxt.unit = wd[0];
        HDC_A_CMD:
        begin
          if (!s_r.bsy && !s_r.drq && wb_sel_i[0] && s_r.unit == UNIT_ID)
          begin
            s_nxt.err = 1'h0;
            if (wd[7:0] == HDC_CMD_HEALTH && s_r.trk == HDC_TRK_KEY)
            begin
              if ((s_r.feat == HDC_FN_RD_VAL || s_r.feat == HDC_FN_RD_THR)
                && s_r.cnt == HDC_CNT_ONE)
              begin
                s_nxt.st = HDC_FILL;
                s_nxt.bsy = 1'h1;
                s_nxt.thr_sel = (s_r.feat == HDC_FN_RD_THR);
                s_nxt.w = 8'h00;
                s_nxt.ent = 5'h00;
                s_nxt.ewd = 3'h0;
                s_nxt.sum = 8'h00;
              end
              else if (s_r.feat == HDC_FN_AUTOSAVE)
              begin
                s_nxt.st = HDC_APPLY;
                s_nxt.bsy = 1'h1;
              end
              else
              begin
                s_nxt.err = 1'h1;
                s_nxt.intrq = 1'h1;
              end
            end
            else
            begin
              s_nxt.err = 1'h1;
              s_nxt.intrq = 1'h1;
            end
          end
        end
        HDC_A_DEVST:
        begin
          s_nxt.ostat = wd[7:0];
          rem = (wd[11:8] > HDC_STEST_MAX) ? HDC_STEST_MAX : wd[11:8];
          s_nxt.stest = {wd[15:12], rem};
        end
        HDC_A_TIMES:
        begin
          s_nxt.otime = wd[15:0];
          s_nxt.poll = wd[31:16];
        end
        HDC_A_CAP: s_nxt.abort_cap = wd[0];
        HDC_A_TBL:
        begin
          s_nxt.tptr = wd[4:0];
          if (wd[4:0] < HDC_ENT_CNT)
          begin
            s_nxt.tbl[wd[4:0]] = wd[23:8];
          end
        end
        HDC_A_DEVCTL:
        begin
          s_nxt.nien = wd[HDC_DC_NIEN];
          srst = wd[HDC_DC_SRST];
        end
        default: s_nxt.ack = acc;
      endcase
    end
    else if (acc)
    begin
      rd = cur;
      // status read acknowledges the interrupt; alternate status does not
      if (wb_adr_i == HDC_A_CMD)
      begin
        s_nxt.intrq = 1'h0;
      end
      if (wb_adr_i == HDC_A_DATA && s_r.st == HDC_XFER)
      begin
        rd = {16'h0000, word_out};
        {s_nxt.w, s_nxt.ent, s_nxt.ewd} = adv;
        if (s_r.w == HDC_W_LAST)
        begin
          s_nxt.drq = 1'h0;
          s_nxt.st = HDC_IDLE;
          s_nxt.cnt = HDC_CNT_DONE;
        end
      end
    end
    s_nxt.rdat = rd;

    // soft reset drops any command in flight
    if (srst)
    begin
      s_nxt.st = HDC_IDLE;
      s_nxt.bsy = 1'h0;
      s_nxt.drq = 1'h0;
      s_nxt.err = 1'h0;
      s_nxt.intrq = 1'h0;
    end
    else
    begin
      case (s_r.st)
        HDC_IDLE: s_nxt.st = s_nxt.st;
        HDC_FILL:
        begin
          // sum words as they are generated; checksum byte excluded
          s_nxt.sum = s_r.sum + word_out[7:0]
            + ((s_r.w == HDC_W_LAST) ? 8'h00 : word_out[15:8]);
          {s_nxt.w, s_nxt.ent, s_nxt.ewd} = adv;
          if (s_r.w == HDC_W_LAST)
          begin
            s_nxt.st = HDC_XFER;
            s_nxt.bsy = 1'h0;
            s_nxt.drq = 1'h1;
            s_nxt.intrq = 1'h1;
            s_nxt.w = 8'h00;
            s_nxt.ent = 5'h00;
            s_nxt.ewd = 3'h0;
          end
        end
        HDC_XFER: s_nxt.st = s_nxt.st;
        HDC_APPLY:
        begin
          if (s_r.cnt == HDC_AS_ON)
          begin
            s_nxt.autosave = 1'h1;
            s_nxt.nv_wr = ~s_r.autosave;
          end
          else if (s_r.cnt == HDC_AS_OFF)
          begin
            s_nxt.autosave = 1'h0;
            s_nxt.nv_wr = s_r.autosave;
          end
          s_nxt.bsy = 1'h0;
          s_nxt.intrq = 1'h1;
          s_nxt.st = HDC_IDLE;
        end
        default: s_nxt.st = HDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
      s_r.st <= HDC_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : hdc_health_cmd

// File: src/hdc_pkg.sv
/*
  Constants, register map and state types for the drive health data
  command block. Assumes a 32-bit Wishbone register bus and a 10 MHz clock.
*/
package hdc_pkg;

  // register byte addresses
  localparam logic [7:0] HDC_A_FEAT = 8'h00;
  localparam logic [7:0] HDC_A_CNT = 8'h04;
  localparam logic [7:0] HDC_A_SUB = 8'h08;
  localparam logic [7:0] HDC_A_TRK = 8'h0C;
  localparam logic [7:0] HDC_A_HEAD = 8'h10;
  localparam logic [7:0] HDC_A_UNIT = 8'h14;
  localparam logic [7:0] HDC_A_CMD = 8'h18;
  localparam logic [7:0] HDC_A_DATA = 8'h1C;
  localparam logic [7:0] HDC_A_DEVST = 8'h20;
  localparam logic [7:0] HDC_A_TIMES = 8'h24;
  localparam logic [7:0] HDC_A_CAP = 8'h28;
  localparam logic [7:0] HDC_A_TBL = 8'h2C;
  localparam logic [7:0] HDC_A_ERR = 8'h30;
  localparam logic [7:0] HDC_A_DEVCTL = 8'h34;

  // command and task-file codes
  localparam logic [7:0] HDC_CMD_HEALTH = 8'hB0;
  localparam logic [7:0] HDC_FN_RD_VAL = 8'hD0;
  localparam logic [7:0] HDC_FN_RD_THR = 8'hD1;
  localparam logic [7:0] HDC_FN_AUTOSAVE = 8'hD2;
  localparam logic [15:0] HDC_TRK_KEY = 16'hC24F;
  localparam logic [7:0] HDC_CNT_ONE = 8'h01;
  localparam logic [7:0] HDC_CNT_DONE = 8'h00;
  localparam logic [7:0] HDC_AS_ON = 8'hF1;
  localparam logic [7:0] HDC_AS_OFF = 8'h00;

  // block layout, in 16-bit words (word n holds bytes 2n and 2n+1)
  localparam logic [15:0] HDC_REV_VAL = 16'h0006;
  localparam logic [15:0] HDC_REV_THR = 16'h0005;
  localparam logic [7:0] HDC_W_ENT_LAST = 8'hB4;
  localparam logic [7:0] HDC_W_STAT = 8'hB5;
  localparam logic [7:0] HDC_W_TIME = 8'hB6;
  localparam logic [7:0] HDC_W_CAP = 8'hB7;
  localparam logic [7:0] HDC_W_SCAP = 8'hB8;
  localparam logic [7:0] HDC_W_POLL = 8'hBA;
  localparam logic [7:0] HDC_W_LAST = 8'hFF;
  localparam logic [2:0] HDC_EWD_LAST = 3'h5;
  localparam int HDC_N_ENT = 30;
  localparam logic [4:0] HDC_ENT_CNT = 5'h1E;

  // capability encodings
  localparam logic [7:0] HDC_CAP_FIXED = 8'h19;
  localparam int HDC_CAP_ABORT_BIT = 2;
  localparam logic [15:0] HDC_SCAP = 16'h0003;
  localparam logic [3:0] HDC_STEST_MAX = 4'h9;

  // status, error and device control byte bits
  localparam int HDC_SB_BSY = 7;
  localparam int HDC_SB_DRQ = 3;
  localparam int HDC_SB_INTRQ = 1;
  localparam int HDC_SB_ERR = 0;
  localparam int HDC_EB_ABRT = 2;
  localparam int HDC_DC_NIEN = 1;
  localparam int HDC_DC_SRST = 2;

  typedef enum logic [3:0] {
    HDC_IDLE = 4'h1,
    HDC_FILL = 4'h2,
    HDC_XFER = 4'h4,
    HDC_APPLY = 4'h8
  } hdc_st_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] feat;
    logic [7:0] cnt;
    logic [7:0] sub;
    logic [15:0] trk;
    logic [3:0] head;
    logic unit;
    logic nien;
    hdc_st_t st;
    logic bsy;
    logic drq;
    logic err;
    logic intrq;
    logic thr_sel;
    logic [7:0] w;
    logic [4:0] ent;
    logic [2:0] ewd;
    logic [7:0] sum;
    logic [7:0] ostat;
    logic [7:0] stest;
    logic [15:0] otime;
    logic [15:0] poll;
    logic abort_cap;
    logic autosave;
    logic nv_ld;
    logic nv_wr;
    logic save_req;
    logic [4:0] tptr;
    logic [HDC_N_ENT-1:0][15:0] tbl;
  } hdc_state_t;

endpackage : hdc_pkg

// File: src/hdc_blk_if.sv
/*
  Carrier between the command engine and the block word generator.
  Assumes the engine drives the word index and all field values.
*/
`timescale 1ns/1ps
interface hdc_blk_if;
  logic thr_sel;
  logic [7:0] w;
  logic [2:0] ewd;
  logic [15:0] entry;
  logic [7:0] ostat;
  logic [7:0] stest;
  logic [15:0] otime;
  logic [15:0] poll;
  logic abort_cap;
  logic [15:0] pair;
  modport src (output thr_sel, w, ewd, entry, ostat, stest, otime, poll,
    abort_cap, input pair);
  modport rom (input thr_sel, w, ewd, entry, ostat, stest, otime, poll,
    abort_cap, output pair);
endinterface : hdc_blk_if

// File: src/hdc_block_rom.sv
/*
  Word generator for the two 512-byte health blocks, one 16-bit word
  per index. Assumes the caller supplies the checksum for the last word.
*/
`timescale 1ns/1ps
module hdc_block_rom
  import hdc_pkg::*;
(
  hdc_blk_if.rom b
);

  logic [7:0] cap8;

  always_comb
  begin
    cap8 = HDC_CAP_FIXED;
    cap8[HDC_CAP_ABORT_BIT] = b.abort_cap;
    b.pair = 16'h0000;
    if (b.w == 8'h00)
    begin
      b.pair = b.thr_sel ? HDC_REV_THR : HDC_REV_VAL;
    end
    else if (b.w <= HDC_W_ENT_LAST)
    begin
      // threshold entries: id in low byte, threshold in high byte; value entries and rest of entry zero
      if (b.thr_sel && b.ewd == 3'h0)
      begin
        b.pair = b.entry;
      end
    end
    else if (!b.thr_sel)
    begin
      case (b.w)
        HDC_W_STAT: b.pair = {b.stest, b.ostat};
        HDC_W_TIME: b.pair = b.otime;
        HDC_W_CAP: b.pair = {cap8, 8'h00};
        HDC_W_SCAP: b.pair = HDC_SCAP;
        HDC_W_POLL: b.pair = b.poll;
        default: b.pair = 16'h0000;
      endcase
    end
  end

endmodule : hdc_block_rom

// File: tb/hdc_health_cmd_assertions.sv
/*
  Port checker for the health command block.
  Assumes it is bound onto hdc_health_cmd and sees only its ports.
*/
`timescale 1ns/1ps
module hdc_health_cmd_assertions
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic mode_change_i,
  input wire logic normal_save_i,
  input wire logic nv_autosave_o,
  input wire logic nv_wr_o,
  input wire logic save_req_o,
  input wire logic bsy_o,
  input wire logic drq_o
);
  logic [8:0] bsy_cnt_r;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // cycles spent busy so far
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i || !bsy_o)
      bsy_cnt_r <= 9'h000;
    else
      bsy_cnt_r <= bsy_cnt_r + 9'h001;
  end

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("access not answered after one cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  busy_excl_a: assert property (!(bsy_o && drq_o))
    else $error("busy and data request together");
  fill_order_a: assert property ($rose(drq_o) |-> $fell(bsy_o))
    else $error("data request not at end of busy");
  busy_len_a: assert property ($fell(bsy_o) |->
    (bsy_cnt_r == 9'h100 && drq_o) || (bsy_cnt_r == 9'h001 && !drq_o))
    else $error("busy length wrong");
  save_cause_a: assert property (save_req_o ==
    $past(normal_save_i || (mode_change_i && nv_autosave_o)))
    else $error("save request does not follow its causes");
  store_pulse_a: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("store pulse longer than one cycle");
  store_change_a: assert property (nv_wr_o |-> nv_autosave_o != $past(nv_autosave_o))
    else $error("store pulse without state change");
endmodule : hdc_health_cmd_assertions

bind hdc_health_cmd hdc_health_cmd_assertions u_chk
(
  .clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .mode_change_i(mode_change_i),
  .normal_save_i(normal_save_i),
  .nv_autosave_o(nv_autosave_o),
  .nv_wr_o(nv_wr_o),
  .save_req_o(save_req_o),
  .bsy_o(bsy_o),
  .drq_o(drq_o)
);

// File: tb/hdc_host_model.sv
/*
  Host controller model: classic Wishbone master for task-file access.
  Assumes a slave on clk_sys_i that acks every access.
*/
`timescale 1ns/1ps
module hdc_host_model
(
  input wire logic clk_sys_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  int lost;

  initial
  begin
    lost = 0;
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'hFF;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // one bus cycle, held until ack is sampled high or 20 clocks have passed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 20);
    if (ack_i !== 1'b1)
      lost++;
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : hdc_host_model

// File: tb/test_drive_health_data_commands.sv
/*
  Self-checking bench for the health command block.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
module test_drive_health_data_commands import hdc_pkg::*;;
  logic clk_sys_i, nrst_i, mode_change_i, normal_save_i;
  logic cyc, stb, we, ack, nv_wr, save_req, intrq, bsy, drq, nv_as, nv_in;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int fails, checked;

  hdc_host_model u_host (.clk_sys_i(clk_sys_i), .ack_i(ack), .rdat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  hdc_health_cmd u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mode_change_i(mode_change_i),
    .normal_save_i(normal_save_i), .nv_autosave_i(nv_in), .nv_autosave_o(nv_as),
    .nv_wr_o(nv_wr), .save_req_o(save_req), .intrq_o(intrq), .bsy_o(bsy), .drq_o(drq));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic results();
    fails += u_host.lost;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    u_host.xfer(w, a, d, q);
    if (u_host.lost != 0)
      results();
  endtask : acc

  task automatic issue(input logic [7:0] fn, input logic [7:0] cnt);
    logic [31:0] q;
    acc(1'b1, HDC_A_FEAT, {24'h0, fn}, q);
    acc(1'b1, HDC_A_CNT, {24'h0, cnt}, q);
    acc(1'b1, HDC_A_TRK, 32'h0000_C24F, q);
    acc(1'b1, HDC_A_CMD, 32'h0000_00B0, q);
  endtask : issue

  // data-in phase: expected words in ex, all others zero except the checksum byte
  task automatic get_block(input logic [15:0] ex [int]);
    logic [31:0] q;
    logic [7:0] sum;
    int n;
    n = 0;
    sum = 8'h00;
    #1;
    chk("busy at start", 32'h2, {bsy, drq});
    while (drq !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    chk("ready flags", 32'h1, {bsy, intrq === 1'b1});
    if (drq !== 1'b1)
    begin
      fails++;
      results();
    end
    acc(1'b0, HDC_A_CMD, 32'h0, q);
    chk("status", 32'h0A, q);
    for (int i = 0; i < 256; i++)
    begin
      acc(1'b0, HDC_A_DATA, 32'h0, q);
      sum = sum + q[7:0] + q[15:8];
      if (i < 255)
        chk($sformatf("word %0d", i), ex.exists(i) ? ex[i] : 16'h0, q);
      else
        chk("byte 510", 32'h0, q[7:0]);
    end
    chk("checksum", 32'h0, sum);
    #1;
    chk("drq after data", 32'h0, drq);
    acc(1'b0, HDC_A_CNT, 32'h0, q);
    chk("count done", 32'h0, q);
  endtask : get_block

  task automatic t_reset();
    logic [31:0] q;
    chk("outputs idle", 32'h0, {ack, bsy, drq, intrq, nv_wr, save_req, nv_as});
    acc(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    acc(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask : t_reset

  task automatic t_codes();
    logic [7:0] oc [10] = '{8'h00, 8'h80, 8'h02, 8'h82, 8'h04, 8'h84, 8'h05, 8'h85,
      8'h06, 8'h86};
    logic [31:0] q;
    logic [7:0] st;
    for (int i = 0; i < 10; i++)
    begin
      st = {(i < 8) ? i[3:0] : 4'hF, i[3:0]};
      acc(1'b1, HDC_A_DEVST, {16'h0, st, oc[i]}, q);
      acc(1'b0, HDC_A_DEVST, 32'h0, q);
      chk("status codes", {16'h0, st, oc[i]}, q);
    end
  endtask : t_codes

  task automatic t_thresholds();
    logic [15:0] ex [int];
    logic [31:0] q;
    acc(1'b1, HDC_A_TBL, 32'h00FD_0100, q);
    acc(1'b1, HDC_A_TBL, 32'h0000_FF1D, q);
    acc(1'b1, HDC_A_TBL, 32'h00FE_551E, q);
    ex[0] = 16'h0005;
    ex[1] = 16'hFD01;
    ex[175] = 16'h00FF;
    issue(8'hD1, 8'h01);
    get_block(ex);
    acc(1'b0, HDC_A_FEAT, 32'h0, q);
    chk("features kept", 32'hD1, q);
    acc(1'b0, HDC_A_TRK, 32'h0, q);
    chk("key kept", 32'hC24F, q);
  endtask : t_thresholds

  task automatic t_values();
    logic [15:0] ex [int];
    logic [31:0] q;
    acc(1'b1, HDC_A_DEVST, 32'h0000_5A82, q);
    acc(1'b0, HDC_A_DEVST, 32'h0, q);
    chk("remaining saturates", 32'h5982, q);
    acc(1'b1, HDC_A_TIMES, 32'h0012_0E10, q);
    acc(1'b1, HDC_A_CAP, 32'h1, q);
    ex[0] = 16'h0006;
    ex[181] = 16'h5982;
    ex[182] = 16'h0E10;
    ex[183] = 16'h1D00;
    ex[184] = 16'h0003;
    ex[186] = 16'h0012;
    issue(8'hD0, 8'h01);
    get_block(ex);
  endtask : t_values

  task automatic t_autosave();
    logic [7:0] cnt [3] = '{8'hF1, 8'h05, 8'h00};
    logic en [3] = '{1'b1, 1'b1, 1'b0};
    logic pls [3] = '{1'b1, 1'b0, 1'b1};
    logic [31:0] q;
    for (int i = 0; i < 3; i++)
    begin
      issue(8'hD2, cnt[i]);
      #1;
      chk("store pulse", pls[i], nv_wr);
      chk("autosave state", en[i], nv_as);
      acc(1'b0, HDC_A_CMD, 32'h0, q);
      chk("done status", 32'h02, q);
      acc(1'b0, HDC_A_CNT, 32'h0, q);
      chk("count kept", cnt[i], q);
      @(posedge clk_sys_i);
      mode_change_i <= 1'b1;
      @(posedge clk_sys_i);
      mode_change_i <= 1'b0;
      #1;
      chk("save on mode change", en[i], save_req);
    end
    @(posedge clk_sys_i);
    normal_save_i <= 1'b1;
    @(posedge clk_sys_i);
    normal_save_i <= 1'b0;
    #1;
    chk("normal save", 32'h1, save_req);
  endtask : t_autosave

  task automatic t_refused();
    logic [31:0] q;
    issue(8'hD1, 8'h02);
    #1;
    chk("refused flags", 32'h1, {bsy, drq, intrq === 1'b1});
    acc(1'b0, HDC_A_ERR, 32'h0, q);
    chk("abort code", 32'h4, q);
    // interrupt mask hides the line, alternate status keeps the flag
    acc(1'b1, HDC_A_DEVCTL, 32'h2, q);
    #1;
    chk("masked irq", 32'h0, intrq);
    acc(1'b0, HDC_A_DEVCTL, 32'h0, q);
    chk("alt status", 32'h03, q);
    acc(1'b1, HDC_A_DEVCTL, 32'h4, q);
    acc(1'b0, HDC_A_CMD, 32'h0, q);
    chk("after soft reset", 32'h0, q);
  endtask : t_refused

  // second reset with the stored autosave state set
  task automatic t_nvload();
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    nv_in <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    #1;
    chk("reset idle", 32'h0, {bsy, drq, intrq, nv_as});
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("autosave restored", 32'h1, nv_as);
  endtask : t_nvload

  initial
  begin
    fails = 0;
    checked = 0;
    nrst_i = 1'b0;
    mode_change_i = 1'b0;
    normal_save_i = 1'b0;
    nv_in = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    #1;
    t_reset();
    t_codes();
    t_thresholds();
    t_values();
    t_autosave();
    t_refused();
    t_nvload();
    results();
  end
endmodule : test_drive_health_data_commands
